// *** hw/slss_pkg.sv ***
package slss_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bus geometry
   localparam int          SLSS_DATA_W        = 32;
   localparam int          SLSS_STRB_W        = SLSS_DATA_W / 8;
   localparam int          SLSS_ENABLE_W      = 8;

   // register byte offsets
   localparam logic [7:0]  SLSS_ENABLES_OFS   = 8'h00;
   localparam logic [7:0]  SLSS_STATUS_OFS    = 8'h04;

   // value after reset: every source disconnected
   localparam logic [7:0]  SLSS_ENABLES_RST   = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // source slots, shared by the set side and the reset side
   localparam int          SLSS_NUM_SRC       = 4;
   localparam int          SLSS_SRC_FIRST_CMP = 0;
   localparam int          SLSS_SRC_SECOND_CMP = 1;
   localparam int          SLSS_SRC_PULSE_CLK = 2;
   localparam int          SLSS_SRC_PIN       = 3;

   // enable bit positions in latch_source_enables
   localparam int          SLSS_PIN_SET_EN_BIT        = 7;
   localparam int          SLSS_PULSE_CLK_SET_EN_BIT  = 6;
   localparam int          SLSS_CMP_TWO_SET_EN_BIT    = 5;
   localparam int          SLSS_CMP_ONE_SET_EN_BIT    = 4;
   localparam int          SLSS_PIN_RST_EN_BIT        = 3;
   localparam int          SLSS_PULSE_CLK_RST_EN_BIT  = 2;
   localparam int          SLSS_CMP_TWO_RST_EN_BIT    = 1;
   localparam int          SLSS_CMP_ONE_RST_EN_BIT    = 0;

   // status register layout
   localparam int          SLSS_STAT_SRC_LSB  = 0;
   localparam int          SLSS_STAT_SET_BIT  = 4;
   localparam int          SLSS_STAT_RST_BIT  = 5;

   // synchroniser depth for asynchronous sources
   localparam int          SLSS_SYNC_STAGES   = 2;

   ////////////////////////////////////////////////////////////////////////////
   // bus answers
   typedef enum logic [1:0] {
      SLSS_RESP_OKAY   = 2'b00,
      SLSS_RESP_SLVERR = 2'b10
   } slss_resp_type;

endpackage : slss_pkg

// *** hw/slss_gate_if.sv ***
`timescale 1ns/1ps
interface slss_gate_if #(
   parameter int NUM_SRC = 4
);
   logic [NUM_SRC-1:0] src;
   logic [NUM_SRC-1:0] en;
   logic               active;

   // top side offers sources and enables, reads the combined request
   modport host (output src, output en, input active);
   modport gate (input src, input en, output active);
endinterface : slss_gate_if

// *** hw/slss_gate.sv ***
`timescale 1ns/1ps
module slss_gate (
   slss_gate_if.gate gate_port
);

   ////////////////////////////////////////////////////////////////////////////
   // any enabled source that is high drives the latch input
   always_comb begin
      gate_port.active = |(gate_port.src & gate_port.en);
   end

endmodule : slss_gate

// *** hw/slss_top.sv ***
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module slss_top
   import slss_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic                   mclk_i,
   input  wire logic                   rst_n_i,
   // write address channel
   input  wire logic [ADDR_W-1:0]      awaddr_i,
   input  wire logic [2:0]             awprot_i,
   input  wire logic                   awvalid_i,
   output logic                        awready_o,
   // write data channel
   input  wire logic [SLSS_DATA_W-1:0] wdata_i,
   input  wire logic [SLSS_STRB_W-1:0] wstrb_i,
   input  wire logic                   wvalid_i,
   output logic                        wready_o,
   // write response channel
   output logic [1:0]                  bresp_o,
   output logic                        bvalid_o,
   input  wire logic                   bready_i,
   // read address channel
   input  wire logic [ADDR_W-1:0]      araddr_i,
   input  wire logic [2:0]             arprot_i,
   input  wire logic                   arvalid_i,
   output logic                        arready_o,
   // read data channel
   output logic [SLSS_DATA_W-1:0]      rdata_o,
   output logic [1:0]                  rresp_o,
   output logic                        rvalid_o,
   input  wire logic                   rready_i,
   // latch sources
   input  wire logic                   latch_input_pin_i,
   input  wire logic                   latch_pulse_clock_i,
   input  wire logic                   first_comparator_i,
   input  wire logic                   second_comparator_i,
   // latch inputs
   output logic                        latch_set_o,
   output logic                        latch_reset_o
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   // latch datapath
   logic [SLSS_ENABLE_W-1:0] enables_reg;
   logic [SLSS_NUM_SRC-1:0]  raw_src;
   logic [SLSS_NUM_SRC-1:0]  sync1_reg;
   logic [SLSS_NUM_SRC-1:0]  sync2_reg;
   logic [SLSS_NUM_SRC-1:0]  set_en_vec;
   logic [SLSS_NUM_SRC-1:0]  rst_en_vec;
   logic                     set_next;
   logic                     rst_next;
   logic                     set_reg;
   logic                     rst_reg;

   // bus holding registers
   logic                     aw_held_reg;
   logic [ADDR_W-1:0]        aw_addr_reg;
   logic                     w_held_reg;
   logic [SLSS_DATA_W-1:0]   w_data_reg;
   logic [SLSS_STRB_W-1:0]   w_strb_reg;
   logic                     bvalid_reg;
   slss_resp_type            bresp_reg;
   logic                     rvalid_reg;
   slss_resp_type            rresp_reg;
   logic [SLSS_DATA_W-1:0]   rdata_reg;

   // bus decode
   logic                     aw_take;
   logic                     w_take;
   logic                     ar_take;
   logic                     wr_fire;
   logic [ADDR_W-1:0]        wr_addr;
   logic [SLSS_DATA_W-1:0]   wr_data;
   logic [SLSS_STRB_W-1:0]   wr_strb;
   logic                     wr_hit_enables;
   logic                     wr_hit_status;
   logic [SLSS_DATA_W-1:0]   rd_data_next;
   slss_resp_type            rd_resp_next;
   logic                     rd_hit_enables;
   logic                     rd_hit_status;

   slss_gate_if #(.NUM_SRC(SLSS_NUM_SRC)) set_bus ();
   slss_gate_if #(.NUM_SRC(SLSS_NUM_SRC)) rst_bus ();

   ////////////////////////////////////////////////////////////////////////////
   // source synchronisers
   // pin and comparators are asynchronous; the pulse clock is synced too so
   // that all four sources see the same latency
   // limitation: a source pulse shorter than one clock period can fall
   // between two sampling edges and be missed altogether
   // from a source change to a latch input there are three edges: two in
   // these stages and one at the output flop
   assign raw_src[SLSS_SRC_PIN]        = latch_input_pin_i;
   assign raw_src[SLSS_SRC_PULSE_CLK]  = latch_pulse_clock_i;
   assign raw_src[SLSS_SRC_SECOND_CMP] = second_comparator_i;
   assign raw_src[SLSS_SRC_FIRST_CMP]  = first_comparator_i;

   // reset clears both stages so no stale level reaches the latch after reset
   // first stage feeds only the second stage
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= raw_src;
         sync2_reg <= sync1_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // enable routing: one bit per source and latch input
   // the upper nibble steers the set side and the lower nibble the reset
   // side; both use one slot order, so a single gate module serves both
   // latch inputs and the two can never disagree on source positions
   assign set_en_vec[SLSS_SRC_PIN]        = enables_reg[SLSS_PIN_SET_EN_BIT];
   assign set_en_vec[SLSS_SRC_PULSE_CLK]  = enables_reg[SLSS_PULSE_CLK_SET_EN_BIT];
   assign set_en_vec[SLSS_SRC_SECOND_CMP] = enables_reg[SLSS_CMP_TWO_SET_EN_BIT];
   assign set_en_vec[SLSS_SRC_FIRST_CMP]  = enables_reg[SLSS_CMP_ONE_SET_EN_BIT];
   assign rst_en_vec[SLSS_SRC_PIN]        = enables_reg[SLSS_PIN_RST_EN_BIT];
   assign rst_en_vec[SLSS_SRC_PULSE_CLK]  = enables_reg[SLSS_PULSE_CLK_RST_EN_BIT];
   assign rst_en_vec[SLSS_SRC_SECOND_CMP] = enables_reg[SLSS_CMP_TWO_RST_EN_BIT];
   assign rst_en_vec[SLSS_SRC_FIRST_CMP]  = enables_reg[SLSS_CMP_ONE_RST_EN_BIT];

   // same synced sources go to both sides
   assign set_bus.src = sync2_reg;
   assign set_bus.en  = set_en_vec;
   assign rst_bus.src = sync2_reg;
   assign rst_bus.en  = rst_en_vec;

   // masked OR of the enabled sources, one instance per latch input
   // both gates see one synced vector, so set and reset stay aligned
   slss_gate u_set_gate (
      .gate_port (set_bus.gate)
   );

   slss_gate u_rst_gate (
      .gate_port (rst_bus.gate)
   );

   assign set_next = set_bus.active;
   assign rst_next = rst_bus.active;

   // latch inputs leave from flip-flops to keep them glitch free
   // set and reset may both be high at once; resolving that belongs to the
   // latch itself, so no priority is imposed here
   // the flop adds one edge of latency, traded for clean outputs
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         set_reg <= 1'b0;
         rst_reg <= 1'b0;
      end else begin
         set_reg <= set_next;
         rst_reg <= rst_next;
      end
   end

   // ports driven straight from the output flops
   assign latch_set_o   = set_reg;
   assign latch_reset_o = rst_reg;

   ////////////////////////////////////////////////////////////////////////////
   // write path: address and data held independently, either order
   // one write in flight; new halves are refused while a response waits
   // the response waits for both halves, and a pending bvalid blocks any
   // further half, so a second write cannot overtake an untaken answer
   // protection bits are accepted and ignored: every register is open to
   // every kind of access
   // ready outputs are combinational, so a free slot is offered at once
   assign awready_o = !aw_held_reg && !bvalid_reg;
   assign wready_o  = !w_held_reg && !bvalid_reg;
   assign aw_take   = awvalid_i && awready_o;
   assign w_take    = wvalid_i && wready_o;

   // a half arriving this cycle is used directly, saving a cycle
   assign wr_addr   = aw_held_reg ? aw_addr_reg : awaddr_i;
   assign wr_data   = w_held_reg ? w_data_reg : wdata_i;
   assign wr_strb   = w_held_reg ? w_strb_reg : wstrb_i;
   assign wr_fire   = (aw_held_reg || aw_take) && (w_held_reg || w_take) && !bvalid_reg;

   assign wr_hit_enables = (wr_addr[ADDR_W-1:2] == SLSS_ENABLES_OFS[ADDR_W-1:2]);
   assign wr_hit_status  = (wr_addr[ADDR_W-1:2] == SLSS_STATUS_OFS[ADDR_W-1:2]);

   // address half
   // only the word index is decoded; the two low address bits are ignored
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= '0;
      end else if (wr_fire) begin
         aw_held_reg <= 1'b0;
      end else if (aw_take) begin
         aw_held_reg <= 1'b1;
         aw_addr_reg <= awaddr_i;
      end
   end

   // data half
   // strobe travels with the data so a late address still finds its lane
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         w_held_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else if (wr_fire) begin
         w_held_reg <= 1'b0;
      end else if (w_take) begin
         w_held_reg <= 1'b1;
         w_data_reg <= wdata_i;
         w_strb_reg <= wstrb_i;
      end
   end

   // enables register: only byte lane 0 carries bits
   // a write with wstrb[0] low is still answered OKAY but changes nothing;
   // upper lanes are dropped because only eight enable bits exist
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         enables_reg <= SLSS_ENABLES_RST;
      end else if (wr_fire && wr_hit_enables && wr_strb[0]) begin
         enables_reg <= wr_data[SLSS_ENABLE_W-1:0];
      end
   end

   // write response; status is read only, so writing it is an error too
   // unmapped offsets answer an error as well and change nothing
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= SLSS_RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= wr_hit_enables ? SLSS_RESP_OKAY : SLSS_RESP_SLVERR;
      end else if (bready_i) begin
         bvalid_reg <= 1'b0;
      end
   end

   // response ports straight from the flops
   assign bvalid_o = bvalid_reg;
   assign bresp_o  = bresp_reg;

   ////////////////////////////////////////////////////////////////////////////
   // read path: one read in flight, answer one cycle after the address
   // arready drops while an answer waits, so the read data registers never
   // change under a pending rvalid
   // bits above the enable byte always read zero
   assign arready_o = !rvalid_reg;
   assign ar_take   = arvalid_i && arready_o;

   // word index compare for the read side, as on the write side
   assign rd_hit_enables = (araddr_i[ADDR_W-1:2] == SLSS_ENABLES_OFS[ADDR_W-1:2]);
   assign rd_hit_status  = (araddr_i[ADDR_W-1:2] == SLSS_STATUS_OFS[ADDR_W-1:2]);

   // read decode; unmapped words read zero with an error
   // status shows the synced sources and the latch inputs as they leave
   always_comb begin
      rd_data_next = '0;
      rd_resp_next = SLSS_RESP_OKAY;
      if (rd_hit_enables) begin
         rd_data_next[SLSS_ENABLE_W-1:0] = enables_reg;
      end else if (rd_hit_status) begin
         rd_data_next[SLSS_STAT_SRC_LSB +: SLSS_NUM_SRC] = sync2_reg;
         rd_data_next[SLSS_STAT_SET_BIT]                 = set_reg;
         rd_data_next[SLSS_STAT_RST_BIT]                 = rst_reg;
      end else begin
         rd_resp_next = SLSS_RESP_SLVERR;
      end
   end

   // read answer held until the master takes it
   // an arvalid arriving while rvalid waits is simply held off
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= SLSS_RESP_OKAY;
      end else if (ar_take) begin
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_data_next;
         rresp_reg  <= rd_resp_next;
      end else if (rready_i) begin
         rvalid_reg <= 1'b0;
      end
   end

   // answer ports straight from the flops
   assign rvalid_o = rvalid_reg;
   assign rdata_o  = rdata_reg;
   assign rresp_o  = rresp_reg;

endmodule : slss_top

// *** verif/slss_src_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
// far side: pin and comparators as levels, pulse clock free-running while asked
module slss_src_model #(
   parameter int HALF = 2
) (
   input  wire logic       mclk_i,
   input  wire logic [3:0] lvl_i,
   input  wire logic       run_i,
   output logic [3:0]      src_o = 4'h0
);
   int   cnt = 0;
   logic tog = 1'b0;
   // pulse clock parks low when stopped so no stale edge leaks out
   always_ff @(posedge mclk_i) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) tog <= run_i ? !tog : 1'b0;
      src_o <= {lvl_i[3], run_i ? tog : lvl_i[2], lvl_i[1:0]};
   end
endmodule : slss_src_model

// *** verif/slss_top_asserts.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
module slss_top_asserts
   import slss_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input wire logic                   mclk_i,
   input wire logic                   rst_n_i,
   input wire logic [ADDR_W-1:0]      awaddr_i,
   input wire logic                   awvalid_i,
   input wire logic                   awready_o,
   input wire logic [SLSS_DATA_W-1:0] wdata_i,
   input wire logic [SLSS_STRB_W-1:0] wstrb_i,
   input wire logic                   wvalid_i,
   input wire logic                   wready_o,
   input wire logic                   latch_input_pin_i,
   input wire logic                   latch_pulse_clock_i,
   input wire logic                   first_comparator_i,
   input wire logic                   second_comparator_i,
   input wire logic                   latch_set_o,
   input wire logic                   latch_reset_o
);
   logic [7:0] en_h;
   logic [7:0] en_d;
   logic [3:0] s1;
   logic [3:0] s2;
   logic [3:0] s3;
   // mirror of the enables; only sees writes whose address and data land together
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) en_h <= SLSS_ENABLES_RST;
      else if (awvalid_i && awready_o && wvalid_i && wready_o && awaddr_i[ADDR_W-1:2] == '0 && wstrb_i[0])
         en_h <= wdata_i[7:0];
   end
   // source delay line, {pin, pulse, cmp2, cmp1}, matching sync plus output flop
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         {en_d, s1, s2, s3} <= '0;
      end else begin
         en_d <= en_h;
         s1 <= {latch_input_pin_i, latch_pulse_clock_i, second_comparator_i, first_comparator_i};
         s2 <= s1;
         s3 <= s2;
      end
   end
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   property p_pin_set; en_d[7] && s3[3] |-> latch_set_o; endproperty
   a_pin_set: assert property (p_pin_set) else $error("pin did not set");
   property p_pulse_set; en_h[6] && s2[2] |=> latch_set_o; endproperty
   a_pulse_set: assert property (p_pulse_set) else $error("pulse did not set");
   property p_cmp2_set; en_d[5] && s3[1] |-> latch_set_o; endproperty
   a_cmp2_set: assert property (p_cmp2_set) else $error("cmp2 did not set");
   property p_cmp1_set; en_h[4] && s2[0] |-> ##1 latch_set_o; endproperty
   a_cmp1_set: assert property (p_cmp1_set) else $error("cmp1 did not set");
   property p_pin_rst; en_d[3] && s3[3] |-> latch_reset_o; endproperty
   a_pin_rst: assert property (p_pin_rst) else $error("pin did not reset");
   property p_pulse_rst; en_h[2] && s2[2] |=> latch_reset_o; endproperty
   a_pulse_rst: assert property (p_pulse_rst) else $error("pulse did not reset");
   property p_cmp2_rst; en_d[1] && s3[1] |-> latch_reset_o; endproperty
   a_cmp2_rst: assert property (p_cmp2_rst) else $error("cmp2 did not reset");
   property p_cmp1_rst; en_h[0] && s2[0] |-> ##1 latch_reset_o; endproperty
   a_cmp1_rst: assert property (p_cmp1_rst) else $error("cmp1 did not reset");
   property p_set_or; latch_set_o == |(en_d[7:4] & s3); endproperty
   a_set_or: assert property (p_set_or) else $error("set is not the enabled OR");
   property p_rst_or; latch_reset_o == |(en_d[3:0] & s3); endproperty
   a_rst_or: assert property (p_rst_or) else $error("reset is not the enabled OR");
   c_both: cover property (latch_set_o && latch_reset_o);
   c_pulse: cover property (en_d[6] && $rose(latch_set_o));
   c_write: cover property (awvalid_i && awready_o && wvalid_i && wready_o);
endmodule : slss_top_asserts

bind slss_top slss_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.mclk_i, .rst_n_i, .awaddr_i, .awvalid_i, .awready_o,
   .wdata_i, .wstrb_i, .wvalid_i, .wready_o, .latch_input_pin_i, .latch_pulse_clock_i, .first_comparator_i,
   .second_comparator_i, .latch_set_o, .latch_reset_o);

// *** verif/test_sr_latch_source_select.sv ***
`timescale 1ns/1ps
////////////////////////////////////////
module test_sr_latch_source_select;
   import slss_pkg::*;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, run = 1'b0;
   logic awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0, arvalid_i = 1'b0, rready_i = 1'b0;
   logic [7:0] awaddr_i = 8'h00, araddr_i = 8'h00;
   logic [31:0] wdata_i = 32'h0, rdata_o;
   logic [3:0] wstrb_i = 4'h0, lvl = 4'h0, src;
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, latch_set_o, latch_reset_o;
   logic [1:0] bresp_o, rresp_o;
   int bad_count = 0, n_checks = 0, cyc = 0;

   slss_top i_dut (.mclk_i, .rst_n_i, .awaddr_i, .awprot_i(3'h0), .awvalid_i, .awready_o, .wdata_i, .wstrb_i,
      .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i, .araddr_i, .arprot_i(3'h0), .arvalid_i, .arready_o,
      .rdata_o, .rresp_o, .rvalid_o, .rready_i, .latch_input_pin_i(src[3]), .latch_pulse_clock_i(src[2]),
      .second_comparator_i(src[1]), .first_comparator_i(src[0]), .latch_set_o, .latch_reset_o);
   slss_src_model i_src (.mclk_i, .lvl_i(lvl), .run_i(run), .src_o(src));

   initial forever #5 mclk_i = ~mclk_i;
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         bad_count++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // handshakes read 1 ns after an edge, once everything has settled
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      logic ta, tw, tb;
      logic [1:0] r;
      awaddr_i <= a;
      wdata_i <= d;
      wstrb_i <= s;
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      bready_i <= 1'b1;
      tb = 1'b0;
      while (!tb) begin
         #1;
         ta = awvalid_i && awready_o;
         tw = wvalid_i && wready_o;
         tb = bvalid_o;
         r = bresp_o;
         @(posedge mclk_i);
         if (ta) awvalid_i <= 1'b0;
         if (tw) wvalid_i <= 1'b0;
      end
      bready_i <= 1'b0;
      @(posedge mclk_i); // idle edge, so the next call never lowers and raises bready in one step
      chk({30'h0, r}, {30'h0, er});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic tr, done;
      logic [31:0] d;
      logic [1:0] r;
      araddr_i <= a;
      arvalid_i <= 1'b1;
      rready_i <= 1'b1;
      done = 1'b0;
      while (!done) begin
         #1;
         tr = arvalid_i && arready_o;
         done = rvalid_o;
         d = rdata_o;
         r = rresp_o;
         @(posedge mclk_i);
         if (tr) arvalid_i <= 1'b0;
      end
      rready_i <= 1'b0;
      @(posedge mclk_i); // idle edge, so the next call never lowers and raises rready in one step
      chk(d, ed);
      chk({30'h0, r}, {30'h0, er});
   endtask : rd

   task automatic outs(input logic es, input logic er);
      #1;
      chk({31'h0, latch_set_o}, {31'h0, es});
      chk({31'h0, latch_reset_o}, {31'h0, er});
      @(posedge mclk_i);
   endtask : outs

   // reset value, byte lane, read-only and unmapped places
   task automatic t_regs;
      rd(SLSS_ENABLES_OFS, 32'h0, SLSS_RESP_OKAY);
      outs(1'b0, 1'b0);
      wr(SLSS_ENABLES_OFS, 32'hffff_ffff, 4'hf, SLSS_RESP_OKAY);
      wr(SLSS_ENABLES_OFS, 32'h0, 4'h0, SLSS_RESP_OKAY);
      rd(SLSS_ENABLES_OFS, 32'h0000_00ff, SLSS_RESP_OKAY);
      wr(SLSS_STATUS_OFS, 32'h0, 4'hf, SLSS_RESP_SLVERR);
      wr(8'h08, 32'h0, 4'hf, SLSS_RESP_SLVERR);
      rd(8'h08, 32'h0, SLSS_RESP_SLVERR);
      $display("test regs done");
   endtask : t_regs

   // one enable at a time: every other source high must not leak through
   task automatic t_single;
      for (int b = 0; b < 8; b++) begin
         wr(SLSS_ENABLES_OFS, 32'(1 << b), 4'h1, SLSS_RESP_OKAY);
         lvl <= ~(4'h1 << (b % 4));
         repeat (5) @(posedge mclk_i);
         outs(1'b0, 1'b0); // disabled sources ignored
         lvl <= 4'h1 << (b % 4);
         repeat (5) @(posedge mclk_i);
         outs(b >= 4, b < 4); // enabled source drives its side
      end
      $display("test single done");
   endtask : t_single

   task automatic t_or;
      wr(SLSS_ENABLES_OFS, 32'h0000_00a5, 4'h1, SLSS_RESP_OKAY);
      for (int v = 0; v < 16; v++) begin
         lvl <= v[3:0];
         repeat (5) @(posedge mclk_i);
         outs(|(v[3:0] & 4'ha), |(v[3:0] & 4'h5)); // every source combination
      end
      rd(SLSS_STATUS_OFS, 32'h0000_003f, SLSS_RESP_OKAY); // synced sources and both latch inputs
      $display("test or done");
   endtask : t_or

   task automatic t_pulse;
      int rises;
      logic last;
      logic [2:0] hist;
      rises = 0;
      last = 1'b0;
      hist = 3'b111; // pulse slot was high from the last level pattern
      wr(SLSS_ENABLES_OFS, 32'h0000_0044, 4'h1, SLSS_RESP_OKAY);
      lvl <= 4'h0;
      run <= 1'b1;
      repeat (40) begin
         #1;
         chk({31'h0, latch_set_o}, {31'h0, hist[2]}); // set follows the pulse three edges late
         chk({31'h0, latch_reset_o}, {31'h0, hist[2]}); // reset follows the same pulse
         if (latch_set_o === 1'b1 && last === 1'b0) rises++;
         last = latch_set_o;
         hist = {hist[1:0], src[2]};
         @(posedge mclk_i);
      end
      chk(32'(rises >= 5), 32'h1); // pulses reach the outputs
      run <= 1'b0;
      repeat (6) @(posedge mclk_i);
      outs(1'b0, 1'b0); // stopped pulse clock leaves both low
      $display("test pulse done");
   endtask : t_pulse

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_single();
      t_or();
      t_pulse();
      finish_test();
   end
endmodule : test_sr_latch_source_select
